// file: shared/rx_pause_stat_pkg.sv
package rx_pause_stat_pkg;

    // Vector and bus shapes
    localparam int NUM_PRIO     = 8;
    localparam int PAUSE_VEC_W  = 9;
    localparam int GLOBAL_SLOT  = 8;
    localparam int QUANTA_W     = 16;
    localparam int PRIO_IDX_W   = 3;

    // Staging slot that holds the single quanta of a global pause frame
    localparam logic [PRIO_IDX_W-1:0] GLOBAL_STAGE_SLOT = 3'h0;

    // Values after reset
    localparam logic [QUANTA_W-1:0]    QUANTA_RST = 16'h0000;
    localparam logic [PAUSE_VEC_W-1:0] VEC_RST    = 9'h000;

endpackage : rx_pause_stat_pkg

// file: rtl/pause_req_hold.sv
`timescale 1ns/1ps
// Per-bit request holder: set by a received pause frame, cleared by the processing logic
module pause_req_hold (
    // Clock and reset
    input  wire logic                                  clock,
    input  wire logic                                  rst,
    // Set and clear pulses
    input  wire logic [rx_pause_stat_pkg::PAUSE_VEC_W-1:0] set_bits,
    input  wire logic [rx_pause_stat_pkg::PAUSE_VEC_W-1:0] clear_bits,
    // Held request vector
    output logic      [rx_pause_stat_pkg::PAUSE_VEC_W-1:0] req
);

    // A set in the same cycle as a clear wins, so no frame is lost
    always_ff @(posedge clock) begin
        if (rst) begin
            req <= rx_pause_stat_pkg::VEC_RST;
        end else begin
            req <= (req & ~clear_bits) | set_bits;
        end
    end

endmodule : pause_req_hold

// file: rtl/rx_pause_stat_indications.sv
`timescale 1ns/1ps
// Receive indications: statistics increments and pause frame reporting
module rx_pause_stat_indications (
    // Clock and reset
    input  wire logic                                          clock,
    input  wire logic                                          rst,
    // Packet summary from the receive parser, valid with rx_pkt_end
    input  wire logic                                          rx_pkt_start,
    input  wire logic                                          rx_pkt_end,
    input  wire logic                                          rx_fcs_good,
    input  wire logic                                          rx_pkt_good,
    input  wire logic                                          rx_is_broadcast,
    input  wire logic                                          rx_is_vlan,
    input  wire logic                                          rx_is_gpause,
    input  wire logic                                          rx_is_ppause,
    input  wire logic                                          rx_len_error,
    input  wire logic [rx_pause_stat_pkg::NUM_PRIO-1:0]        rx_prio_enable,
    // Quanta fields as the parser extracts them
    input  wire logic                                          rx_quanta_wr,
    input  wire logic [rx_pause_stat_pkg::PRIO_IDX_W-1:0]      rx_quanta_idx,
    input  wire logic [rx_pause_stat_pkg::QUANTA_W-1:0]        rx_quanta_word,
    // Completion pulses from the pause processing logic
    input  wire logic [rx_pause_stat_pkg::PAUSE_VEC_W-1:0]     rx_pause_done,
    // Statistics increments
    output logic                                               rx_bcast_inc,
    output logic                                               rx_vlan_inc,
    output logic                                               rx_gpause_inc,
    output logic                                               rx_ppause_inc,
    output logic                                               rx_inrange_err_inc,
    // Pause reporting
    output logic      [rx_pause_stat_pkg::PAUSE_VEC_W-1:0]     rx_flowctl_valid,
    output logic      [rx_pause_stat_pkg::QUANTA_W-1:0]        rx_flowctl_quanta_prio0,
    output logic      [rx_pause_stat_pkg::QUANTA_W-1:0]        rx_flowctl_quanta_prio1,
    output logic      [rx_pause_stat_pkg::QUANTA_W-1:0]        rx_flowctl_quanta_prio2,
    output logic      [rx_pause_stat_pkg::QUANTA_W-1:0]        rx_flowctl_quanta_prio3,
    output logic      [rx_pause_stat_pkg::QUANTA_W-1:0]        rx_flowctl_quanta_prio4,
    output logic      [rx_pause_stat_pkg::QUANTA_W-1:0]        rx_flowctl_quanta_prio5,
    output logic      [rx_pause_stat_pkg::QUANTA_W-1:0]        rx_flowctl_quanta_prio6,
    output logic      [rx_pause_stat_pkg::QUANTA_W-1:0]        rx_flowctl_quanta_prio7,
    output logic      [rx_pause_stat_pkg::QUANTA_W-1:0]        rx_flowctl_quanta_global,
    output logic      [rx_pause_stat_pkg::PAUSE_VEC_W-1:0]     rx_flowctl_req
);

    // Qualifies a classification flag with the end of packet and a health condition
    function automatic logic counted(input logic flag, input logic healthy);
        counted = rx_pkt_end & healthy & flag;
    endfunction : counted

    // Quanta captured during the current frame, one slot per priority
    logic [rx_pause_stat_pkg::QUANTA_W-1:0]    quanta_stage [rx_pause_stat_pkg::NUM_PRIO];
    logic [rx_pause_stat_pkg::QUANTA_W-1:0]    next_stage   [rx_pause_stat_pkg::NUM_PRIO];

    // Event decode for the current cycle
    logic                                      next_bcast;
    logic                                      next_vlan;
    logic                                      next_gpause;
    logic                                      next_ppause;
    logic                                      next_inrange;
    logic [rx_pause_stat_pkg::PAUSE_VEC_W-1:0] next_valid;

    // Increment decode; only good packets count broadcast and VLAN
    always_comb begin
        next_bcast   = counted(rx_is_broadcast, rx_pkt_good);
        next_vlan    = counted(rx_is_vlan, rx_pkt_good);
        next_inrange = counted(rx_len_error, rx_fcs_good);
    end

    // Pause decode; a frame flagged as both kinds counts as global only
    always_comb begin
        next_gpause  = counted(rx_is_gpause, rx_fcs_good);
        next_ppause  = counted(rx_is_ppause & ~rx_is_gpause, rx_fcs_good);
    end

    // Valid vector: global frame lights bit 8, priority frame its enabled classes
    always_comb begin
        next_valid = rx_pause_stat_pkg::VEC_RST;
        if (next_gpause) begin
            next_valid[rx_pause_stat_pkg::GLOBAL_SLOT] = 1'b1;
        end else if (next_ppause) begin
            next_valid[rx_pause_stat_pkg::NUM_PRIO-1:0] = rx_prio_enable;
        end
    end

    // Staging view with a same-cycle quanta write folded in
    always_comb begin
        for (int i = 0; i < rx_pause_stat_pkg::NUM_PRIO; i++) begin
            next_stage[i] = quanta_stage[i];
            if (rx_quanta_wr && (rx_quanta_idx == i[rx_pause_stat_pkg::PRIO_IDX_W-1:0])) begin
                next_stage[i] = rx_quanta_word;
            end
        end
    end

    // Staging slots; a new frame clears them unless a quanta write falls in the same cycle, which only updates its own slot
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < rx_pause_stat_pkg::NUM_PRIO; i++) begin
                quanta_stage[i] <= rx_pause_stat_pkg::QUANTA_RST;
            end
        end else if (rx_pkt_start && !rx_quanta_wr) begin
            for (int i = 0; i < rx_pause_stat_pkg::NUM_PRIO; i++) begin
                quanta_stage[i] <= rx_pause_stat_pkg::QUANTA_RST;
            end
        end else begin
            for (int i = 0; i < rx_pause_stat_pkg::NUM_PRIO; i++) begin
                quanta_stage[i] <= next_stage[i];
            end
        end
    end

    // Increment strobes, each a single registered cycle per event
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_bcast_inc       <= 1'b0;
            rx_vlan_inc        <= 1'b0;
            rx_gpause_inc      <= 1'b0;
            rx_ppause_inc      <= 1'b0;
            rx_inrange_err_inc <= 1'b0;
        end else begin
            rx_bcast_inc       <= next_bcast;
            rx_vlan_inc        <= next_vlan;
            rx_gpause_inc      <= next_gpause;
            rx_ppause_inc      <= next_ppause;
            rx_inrange_err_inc <= next_inrange;
        end
    end

    // Valid pulse for one cycle per accepted pause frame
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_flowctl_valid <= rx_pause_stat_pkg::VEC_RST;
        end else begin
            rx_flowctl_valid <= next_valid;
        end
    end

    // Priority 0 quanta bus, refreshed only with its valid bit
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_flowctl_quanta_prio0 <= rx_pause_stat_pkg::QUANTA_RST;
        end else if (next_valid[0]) begin
            rx_flowctl_quanta_prio0 <= next_stage[0];
        end
    end

    // Priority 1 quanta bus, refreshed only with its valid bit
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_flowctl_quanta_prio1 <= rx_pause_stat_pkg::QUANTA_RST;
        end else if (next_valid[1]) begin
            rx_flowctl_quanta_prio1 <= next_stage[1];
        end
    end

    // Priority 2 quanta bus, refreshed only with its valid bit
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_flowctl_quanta_prio2 <= rx_pause_stat_pkg::QUANTA_RST;
        end else if (next_valid[2]) begin
            rx_flowctl_quanta_prio2 <= next_stage[2];
        end
    end

    // Priority 3 quanta bus, refreshed only with its valid bit
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_flowctl_quanta_prio3 <= rx_pause_stat_pkg::QUANTA_RST;
        end else if (next_valid[3]) begin
            rx_flowctl_quanta_prio3 <= next_stage[3];
        end
    end

    // Priority 4 quanta bus, refreshed only with its valid bit
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_flowctl_quanta_prio4 <= rx_pause_stat_pkg::QUANTA_RST;
        end else if (next_valid[4]) begin
            rx_flowctl_quanta_prio4 <= next_stage[4];
        end
    end

    // Priority 5 quanta bus, refreshed only with its valid bit
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_flowctl_quanta_prio5 <= rx_pause_stat_pkg::QUANTA_RST;
        end else if (next_valid[5]) begin
            rx_flowctl_quanta_prio5 <= next_stage[5];
        end
    end

    // Priority 6 quanta bus, refreshed only with its valid bit
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_flowctl_quanta_prio6 <= rx_pause_stat_pkg::QUANTA_RST;
        end else if (next_valid[6]) begin
            rx_flowctl_quanta_prio6 <= next_stage[6];
        end
    end

    // Priority 7 quanta bus, refreshed only with its valid bit
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_flowctl_quanta_prio7 <= rx_pause_stat_pkg::QUANTA_RST;
        end else if (next_valid[7]) begin
            rx_flowctl_quanta_prio7 <= next_stage[7];
        end
    end

    // Global quanta bus takes the staged word of a global frame and then holds it
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_flowctl_quanta_global <= rx_pause_stat_pkg::QUANTA_RST;
        end else if (next_valid[rx_pause_stat_pkg::GLOBAL_SLOT]) begin
            rx_flowctl_quanta_global <= next_stage[rx_pause_stat_pkg::GLOBAL_STAGE_SLOT];
        end
    end

    // Held pause requests, released by the processing logic
    pause_req_hold u_req_hold (
        .clock      (clock),
        .rst        (rst),
        .set_bits   (next_valid),
        .clear_bits (rx_pause_done),
        .req        (rx_flowctl_req)
    );

endmodule : rx_pause_stat_indications

// file: verif/rx_pause_stat_checker.sv
`timescale 1ns/1ps
// Port checks of the receive increments and pause reporting
module rx_pause_stat_checker (
    // Clock, reset and packet summary
    input wire logic        clock, rst, rx_pkt_end, rx_fcs_good, rx_pkt_good, rx_is_broadcast,
    input wire logic        rx_is_vlan, rx_is_gpause, rx_is_ppause, rx_len_error,
    input wire logic [7:0]  rx_prio_enable,
    input wire logic [8:0]  rx_pause_done,
    // Block outputs
    input wire logic        rx_bcast_inc, rx_vlan_inc, rx_gpause_inc, rx_ppause_inc, rx_inrange_err_inc,
    input wire logic [8:0]  rx_flowctl_valid, rx_flowctl_req,
    input wire logic [15:0] rx_flowctl_quanta_global
);
    // All checks on the rising edge, idle in reset
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    AST_BCAST: assert property (rx_pkt_end && rx_pkt_good && rx_is_broadcast |=> rx_bcast_inc)
        else $error("broadcast increment missing");
    AST_VLAN: assert property (rx_vlan_inc |-> $past(rx_pkt_end && rx_pkt_good && rx_is_vlan))
        else $error("vlan increment without cause");
    AST_GPAUSE: assert property (rx_pkt_end && rx_fcs_good && rx_is_gpause
        |=> rx_gpause_inc && rx_flowctl_valid == 9'h100)
        else $error("global pause not reported");
    AST_PPAUSE: assert property (rx_pkt_end && rx_fcs_good && rx_is_ppause && !rx_is_gpause
        |=> rx_ppause_inc && rx_flowctl_valid == {1'b0, $past(rx_prio_enable)})
        else $error("priority pause not reported");
    AST_BADFCS: assert property (rx_pkt_end && !rx_fcs_good
        |=> !rx_inrange_err_inc && rx_flowctl_valid == 9'h000)
        else $error("bad frame reported");
    AST_ONCE: assert property (rx_gpause_inc && !(rx_pkt_end && rx_fcs_good && rx_is_gpause)
        |=> !rx_gpause_inc)
        else $error("increment longer than one cycle");
    AST_QHOLD: assert property (!rx_flowctl_valid[8] |-> $stable(rx_flowctl_quanta_global))
        else $error("global quanta changed without valid");
    AST_REQSET: assert property ($rose(rx_flowctl_req[8]) |-> rx_flowctl_valid[8])
        else $error("request raised without pause");
    AST_REQHOLD: assert property (rx_flowctl_req[8] && !rx_pause_done[8] |=> rx_flowctl_req[8])
        else $error("request dropped before done");
endmodule : rx_pause_stat_checker

// file: verif/pause_proc_model.sv
`timescale 1ns/1ps
// Pause processing stand-in: takes quanta on valid, ends each request after a wait
module pause_proc_model (
    // Clock, reset and pause reporting
    input  wire logic        clock, rst,
    input  wire logic [8:0]  rx_flowctl_valid, rx_flowctl_req,
    input  wire logic [15:0] rx_flowctl_quanta_global,
    input  wire logic [3:0]  wait_cycles,
    // Completion pulses
    output logic      [8:0]  rx_pause_done
);
    logic [3:0]  cnt [9];
    logic [15:0] taken;
    // Quanta are used only while valid is high
    always_ff @(posedge clock) begin
        if (rst) taken <= 16'h0000;
        else if (rx_flowctl_valid[8]) taken <= rx_flowctl_quanta_global;
    end
    // One done pulse per pending request, after a prompt or slow wait
    always_ff @(posedge clock) begin
        for (int i = 0; i < 9; i++) begin
            rx_pause_done[i] <= 1'b0;
            if (rst) cnt[i] <= 4'h0;
            else if (rx_flowctl_req[i] && !rx_pause_done[i]) begin
                cnt[i] <= (cnt[i] == wait_cycles) ? 4'h0 : cnt[i] + 4'h1;
                rx_pause_done[i] <= (cnt[i] == wait_cycles);
            end
        end
    end
endmodule : pause_proc_model

// file: verif/tb.sv
`timescale 1ns/1ps
// Random frame traffic against a cycle model
module tb;
    logic        clock, rst, rx_pkt_start, rx_pkt_end, rx_fcs_good, rx_pkt_good, rx_is_broadcast, rx_is_vlan;
    logic        rx_is_gpause, rx_is_ppause, rx_len_error, rx_quanta_wr, rx_bcast_inc, rx_vlan_inc;
    logic        rx_gpause_inc, rx_ppause_inc, rx_inrange_err_inc;
    logic [7:0]  rx_prio_enable;
    logic [2:0]  rx_quanta_idx;
    logic [3:0]  wait_cycles;
    logic [8:0]  rx_pause_done, rx_flowctl_valid, rx_flowctl_req;
    logic [15:0] rx_quanta_word, rx_flowctl_quanta_prio0, rx_flowctl_quanta_prio1, rx_flowctl_quanta_prio2;
    logic [15:0] rx_flowctl_quanta_prio3, rx_flowctl_quanta_prio4, rx_flowctl_quanta_prio5;
    logic [15:0] rx_flowctl_quanta_prio6, rx_flowctl_quanta_prio7, rx_flowctl_quanta_global;
    logic [8:0][15:0] q_out;
    logic [4:0]  inc_out;
    logic [31:0] seed = 32'h00007e8a;
    int          fails = 0, n_tests = 0, cyc = 0, exp_inc = 0, exp_valid = 0, exp_req = 0, exp_taken = 0;
    int          slot [8];
    int          exp_q [9] = '{default: 0};
    assign q_out = {rx_flowctl_quanta_global, rx_flowctl_quanta_prio7, rx_flowctl_quanta_prio6,
        rx_flowctl_quanta_prio5, rx_flowctl_quanta_prio4, rx_flowctl_quanta_prio3, rx_flowctl_quanta_prio2,
        rx_flowctl_quanta_prio1, rx_flowctl_quanta_prio0};
    assign inc_out = {rx_bcast_inc, rx_vlan_inc, rx_gpause_inc, rx_ppause_inc, rx_inrange_err_inc};
    rx_pause_stat_indications DUT (.clock, .rst, .rx_pkt_start, .rx_pkt_end, .rx_fcs_good, .rx_pkt_good,
        .rx_is_broadcast, .rx_is_vlan, .rx_is_gpause, .rx_is_ppause, .rx_len_error, .rx_prio_enable,
        .rx_quanta_wr, .rx_quanta_idx, .rx_quanta_word, .rx_pause_done, .rx_bcast_inc, .rx_vlan_inc,
        .rx_gpause_inc, .rx_ppause_inc, .rx_inrange_err_inc, .rx_flowctl_valid, .rx_flowctl_quanta_prio0,
        .rx_flowctl_quanta_prio1, .rx_flowctl_quanta_prio2, .rx_flowctl_quanta_prio3, .rx_flowctl_quanta_prio4,
        .rx_flowctl_quanta_prio5, .rx_flowctl_quanta_prio6, .rx_flowctl_quanta_prio7,
        .rx_flowctl_quanta_global, .rx_flowctl_req);
    pause_proc_model far_side (.clock, .rst, .rx_flowctl_valid, .rx_flowctl_req, .rx_flowctl_quanta_global,
        .wait_cycles, .rx_pause_done);
    // Xorshift step
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // Shared compare and count
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // One compare per kind of result
    task automatic chk_inc(input logic [4:0] got, input int exp);
        cmp({11'h000, got}, exp[15:0]);
    endtask : chk_inc
    task automatic chk_valid(input logic [8:0] got, input int exp);
        cmp({7'h00, got}, exp[15:0]);
    endtask : chk_valid
    task automatic chk_req(input logic [8:0] got, input int exp);
        cmp({7'h00, got}, exp[15:0]);
    endtask : chk_req
    task automatic chk_quanta(input logic [15:0] got, input int exp);
        cmp(got, exp[15:0]);
    endtask : chk_quanta
    task automatic tally_and_finish;
        if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    // Expected outputs for the inputs the next edge will take
    task automatic model_step;
        logic f, gp, pp;
        int   v;
        if (rx_quanta_wr) slot[rx_quanta_idx] = rx_quanta_word;
        else if (rx_pkt_start) slot = '{default: 0};
        f  = rx_pkt_end && rx_fcs_good;
        gp = f && rx_is_gpause;
        pp = f && rx_is_ppause && !rx_is_gpause;
        exp_inc = {rx_pkt_end && rx_pkt_good && rx_is_broadcast, rx_pkt_end && rx_pkt_good && rx_is_vlan,
            gp, pp, f && rx_len_error};
        v = gp ? 'h100 : (pp ? rx_prio_enable : 0);
        for (int k = 0; k < 8; k++) if (v[k]) exp_q[k] = slot[k];
        if (gp) exp_q[8] = slot[0];
        exp_req = (exp_req & ~rx_pause_done) | v;
        exp_valid = v;
    endtask : model_step
    // Clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Cycle ceiling
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            tally_and_finish();
        end
    end
    // Reset, slot preload, then random back-to-back frames
    initial begin
        rst = 1'b1;
        {rx_pkt_start, rx_pkt_end, rx_fcs_good, rx_pkt_good, rx_is_broadcast, rx_is_vlan, rx_is_gpause,
            rx_is_ppause, rx_len_error, rx_prio_enable, rx_quanta_wr, rx_quanta_idx, rx_quanta_word, wait_cycles} = '0;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        #1;
        for (int i = 0; i < 2000; i++) begin
            @(posedge clock);
            seed = xs(seed);
            rx_pkt_end <= seed[0] && i >= 8;
            rx_pkt_good <= seed[1];
            rx_fcs_good <= seed[1] | seed[2];
            {rx_is_broadcast, rx_is_vlan, rx_is_ppause} <= seed[5:3];
            rx_is_gpause <= seed[6] & seed[7];
            rx_len_error <= seed[8] & seed[9];
            rx_prio_enable <= seed[17:10];
            rx_quanta_wr <= seed[18] || i < 8;
            rx_quanta_idx <= (i < 8) ? i[2:0] : seed[21:19];
            wait_cycles <= seed[25:22];
            rx_pkt_start <= seed[26] & seed[27] & !seed[18] & !seed[0] & i >= 8;
            rx_quanta_word <= seed[31:16] ^ seed[15:0];
            #1;
            chk_inc(inc_out, exp_inc);
            chk_valid(rx_flowctl_valid, exp_valid);
            chk_req(rx_flowctl_req, exp_req);
            for (int k = 0; k < 9; k++) chk_quanta(q_out[k], exp_q[k]);
            chk_quanta(far_side.taken, exp_taken);
            if (exp_valid[8]) exp_taken = exp_q[8];
            model_step();
        end
        tally_and_finish();
    end
endmodule : tb
bind rx_pause_stat_indications rx_pause_stat_checker chk_i (.clock, .rst, .rx_pkt_end, .rx_fcs_good, .rx_pkt_good,
    .rx_is_broadcast, .rx_is_vlan, .rx_is_gpause, .rx_is_ppause, .rx_len_error, .rx_prio_enable, .rx_pause_done,
    .rx_bcast_inc, .rx_vlan_inc, .rx_gpause_inc, .rx_ppause_inc, .rx_inrange_err_inc, .rx_flowctl_valid,
    .rx_flowctl_req, .rx_flowctl_quanta_global);
